// [core/tse_regs.svh]
// constants for the trigger origin selector and shaft encoder decoder
// Summary of operation
// [RQ1] any of three input pins may be the external trigger origin
// [RQ2] shaft encoder output selectable only for the single-row trigger
// [RQ3] timer one done event is an origin for single and multi image triggers
// [RQ4] counter one done event is an origin for single and multi image triggers
// [RQ5] timer one running level holds the trigger active while running
// [RQ6] counter one running level holds the trigger active while running
// [RQ7] time stamp wrap event may be chosen as origin
// [RQ8] broadcast commands one or two trigger single and multi image triggers
// [RQ9] edge selection applies only to external input pins
// [RQ10] rising mode takes rising transitions after optional inversion
// [RQ11] falling mode takes falling edges; any mode takes both
// [RQ12] valid trigger waits a programmable microsecond delay before firing
// [RQ13] position mode tracks reverse travel in a small 9-bit counter
// [RQ14] reverse count saturates beyond 256 ticks and does not reset
// [RQ15] forward travel first cancels stored reverse ticks, then pulses resume
// [RQ16] motion mode pulses on every increment in either direction
// [RQ17] a setting chooses which phase relation counts as forward
// [RQ18] clockwise: B leads A is forward; counter-clockwise: A leads B
// [RQ19] origin honoured only while the chosen trigger is armed
// [RQ20] single row, single image and multi image triggers are distinct
// [RQ21] encoder advances on rising edges, or both edges in any-edge mode
// [RQ22] pins and encoder phases pass a two-stage synchroniser first
// [RQ23] encoder phase transitions are at least one clock apart
`ifndef TSE_REGS_SVH
`define TSE_REGS_SVH
// ----------------------------------------
// origin codes
// ----------------------------------------
`define TSE_SRC_PIN1 4'h0
`define TSE_SRC_PIN2 4'h1
`define TSE_SRC_PIN3 4'h2
`define TSE_SRC_SHAFT 4'h3
`define TSE_SRC_TMR_END 4'h4
`define TSE_SRC_CNT_END 4'h5
`define TSE_SRC_TMR_RUN 4'h6
`define TSE_SRC_CNT_RUN 4'h7
`define TSE_SRC_TS_WRAP 4'h8
`define TSE_SRC_CMD1 4'h9
`define TSE_SRC_CMD2 4'hA
// ----------------------------------------
// target and edge codes
// ----------------------------------------
`define TSE_TGT_ROW 2'h0
`define TSE_TGT_IMAGE 2'h1
`define TSE_TGT_MULTI 2'h2
`define TSE_EDGE_RISE 2'h0
`define TSE_EDGE_FALL 2'h1
`define TSE_EDGE_ANY 2'h2
// ----------------------------------------
// timing and encoder figures
// ----------------------------------------
`define TSE_CLK_MHZ 100
`define TSE_REV_LIMIT 256
`define TSE_REV_WIDTH 9
`endif

// [core/tse_pkg.sv]
// types for the trigger origin selector
package tse_pkg;
	typedef enum logic [1:0] {TSE_IDLE, TSE_WAIT, TSE_FIRE} tse_dly_t;
endpackage

// [core/tse_shaft.sv]
// quadrature shaft encoder decoder with position and motion modes
`timescale 1ns/1ps
`include "tse_regs.svh"
module tse_shaft (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	// settings
	input wire logic position_mode_i,
	input wire logic forward_ccw_i,
	input wire logic any_edge_i,
	// synchronised phases
	input wire logic phase_a_i,
	input wire logic phase_b_i,
	// output
	output logic pulse_o
);
	logic a_q, b_q;
	logic [`TSE_REV_WIDTH-1:0] rev_q;
	logic step, fwd, rise_a, rise_b, ab;
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			a_q <= 1'b0;
			b_q <= 1'b0;
		end else begin
			a_q <= phase_a_i;
			b_q <= phase_b_i;
		end
	end
	assign rise_a = phase_a_i & ~a_q;
	assign rise_b = phase_b_i & ~b_q;
	// see [RQ21]
	assign step = any_edge_i ? ((phase_a_i ^ a_q) | (phase_b_i ^ b_q)) : (rise_a | rise_b);
	// gray step direction: a change on A with A!=B means A leads
	assign ab = (phase_a_i ^ a_q) ? (phase_a_i != phase_b_i) : (phase_a_i == phase_b_i); // see [RQ23]
	// see [RQ17] see [RQ18]
	assign fwd = forward_ccw_i ? ab : ~ab;
	// reverse counter saturates and never clears on its own; see [RQ13] see [RQ14]
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rev_q <= '0;
		end else if (!position_mode_i) begin
			rev_q <= '0;
		end else if (step && !fwd && rev_q != `TSE_REV_WIDTH'(`TSE_REV_LIMIT)) begin
			rev_q <= rev_q + `TSE_REV_WIDTH'(1);
		end else if (step && fwd && rev_q != '0) begin
			rev_q <= rev_q - `TSE_REV_WIDTH'(1); // see [RQ15]
		end
	end
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pulse_o <= 1'b0;
		end else begin
			// see [RQ16] see [RQ15]
			pulse_o <= step & (position_mode_i ? (fwd & rev_q == '0) : 1'b1);
		end
	end
endmodule // tse_shaft

// [core/tse_top.sv]
// trigger origin selection, edge qualification and holdoff delay
`timescale 1ns/1ps
`include "tse_regs.svh"
module tse_top import tse_pkg::*; #(
	parameter int DELAY_WIDTH = 16
) (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic rstn_i,
	// external pins
	input wire logic input_pin_one_i,
	input wire logic input_pin_two_i,
	input wire logic input_pin_three_i,
	input wire logic [2:0] pin_invert_i,
	input wire logic shaft_phase_a_i,
	input wire logic shaft_phase_b_i,
	// internal events and levels
	input wire logic timer_one_done_event_i,
	input wire logic counter_one_done_event_i,
	input wire logic timer_one_running_i,
	input wire logic counter_one_running_i,
	input wire logic time_stamp_wrap_event_i,
	input wire logic broadcast_cmd_one_i,
	input wire logic broadcast_cmd_two_i,
	// settings
	input wire logic [1:0] trigger_target_i,
	input wire logic trigger_arm_i,
	input wire logic [3:0] trigger_origin_select_i,
	input wire logic [1:0] trigger_edge_select_i,
	input wire logic [DELAY_WIDTH-1:0] trigger_holdoff_us_i,
	input wire logic shaft_output_mode_i,
	input wire logic shaft_forward_phase_i,
	input wire logic shaft_edge_select_i,
	// outputs
	output logic single_row_trigger_o,
	output logic single_image_trigger_o,
	output logic multi_image_trigger_o,
	output logic trigger_level_o,
	output logic shaft_pulse_origin_o
);
	// elaboration check: the holdoff counter cannot serve other widths
	if (DELAY_WIDTH < 1 || DELAY_WIDTH > 24) begin : g_bad_width
		$error("DELAY_WIDTH out of range");
	end
	// ----------------------------------------
	// reset release
	// ----------------------------------------
	logic rst_s1_q, rst_n;
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rst_s1_q <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_n <= rst_s1_q;
		end
	end
	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic [4:0] raw, s1_q, s2_q;
	assign raw = {shaft_phase_b_i, shaft_phase_a_i, input_pin_three_i, input_pin_two_i, input_pin_one_i};
	genvar gi;
	generate
		for (gi = 0; gi < 5; gi++) begin : g_sync
			always_ff @(posedge ref_clk_i or negedge rst_n) begin
				if (!rst_n) begin
					s1_q[gi] <= 1'b0;
					s2_q[gi] <= 1'b0;
				end else begin
					s1_q[gi] <= raw[gi]; // see [RQ22]
					s2_q[gi] <= s1_q[gi];
				end
			end
		end
	endgenerate
	// ----------------------------------------
	// line edge qualification
	// ----------------------------------------
	logic [2:0] line_now, line_q;
	assign line_now = s2_q[2:0] ^ pin_invert_i; // see [RQ10]
	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			line_q <= 3'h0;
		end else begin
			// raw level kept so an inversion change or reset never looks like an edge
			line_q <= s2_q[2:0];
		end
	end
	logic sel_now, sel_old, line_ok;
	always_comb begin
		sel_now = 1'b0;
		sel_old = 1'b0;
		if (trigger_origin_select_i <= `TSE_SRC_PIN3) begin
			sel_now = line_now[trigger_origin_select_i[1:0]]; // see [RQ1]
			sel_old = line_q[trigger_origin_select_i[1:0]] ^ pin_invert_i[trigger_origin_select_i[1:0]];
		end
	end
	always_comb begin
		unique case (trigger_edge_select_i)
			`TSE_EDGE_RISE: line_ok = sel_now & ~sel_old; // see [RQ10]
			`TSE_EDGE_FALL: line_ok = ~sel_now & sel_old; // see [RQ11]
			default: line_ok = sel_now ^ sel_old; // see [RQ11]
		endcase
	end
	// ----------------------------------------
	// shaft decoder
	// ----------------------------------------
	logic shaft_pulse;
	tse_shaft u_shaft (
		.ref_clk_i(ref_clk_i),
		.rst_n_i(rst_n),
		.position_mode_i(shaft_output_mode_i),
		.forward_ccw_i(shaft_forward_phase_i),
		.any_edge_i(shaft_edge_select_i),
		.phase_a_i(s2_q[3]),
		.phase_b_i(s2_q[4]),
		.pulse_o(shaft_pulse)
	);
	// ----------------------------------------
	// origin multiplexer
	// ----------------------------------------
	logic is_row, is_img, ev, lvl, lvl_src;
	assign is_row = trigger_target_i == `TSE_TGT_ROW;
	assign is_img = trigger_target_i == `TSE_TGT_IMAGE || trigger_target_i == `TSE_TGT_MULTI;
	always_comb begin
		ev = 1'b0;
		lvl_src = 1'b0;
		lvl = 1'b0;
		unique case (trigger_origin_select_i)
			`TSE_SRC_PIN1, `TSE_SRC_PIN2, `TSE_SRC_PIN3: ev = line_ok; // see [RQ9]
			`TSE_SRC_SHAFT: ev = shaft_pulse & is_row; // see [RQ2]
			`TSE_SRC_TMR_END: ev = timer_one_done_event_i & is_img; // see [RQ3]
			`TSE_SRC_CNT_END: ev = counter_one_done_event_i & is_img; // see [RQ4]
			`TSE_SRC_TMR_RUN: begin
				lvl_src = 1'b1;
				lvl = timer_one_running_i; // see [RQ5]
			end
			`TSE_SRC_CNT_RUN: begin
				lvl_src = 1'b1;
				lvl = counter_one_running_i; // see [RQ6]
			end
			`TSE_SRC_TS_WRAP: ev = time_stamp_wrap_event_i; // see [RQ7]
			`TSE_SRC_CMD1: ev = broadcast_cmd_one_i & is_img; // see [RQ8]
			`TSE_SRC_CMD2: ev = broadcast_cmd_two_i & is_img; // see [RQ8]
			default: ev = 1'b0;
		endcase
	end
	// ----------------------------------------
	// holdoff delay
	// ----------------------------------------
	// a trigger arriving while a delay runs is dropped, so fire spacing stays at least the delay
	localparam int UNIT = `TSE_CLK_MHZ;
	tse_dly_t st_q;
	logic [DELAY_WIDTH-1:0] us_q;
	logic [6:0] sub_q;
	logic fire;
	assign fire = st_q == TSE_FIRE;
	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= TSE_IDLE;
			us_q <= '0;
			sub_q <= 7'h00;
		end else begin
			unique case (st_q)
				TSE_IDLE: begin
					if (ev && trigger_arm_i) begin // see [RQ19]
						us_q <= trigger_holdoff_us_i;
						sub_q <= 7'(UNIT - 1);
						st_q <= (trigger_holdoff_us_i == '0) ? TSE_FIRE : TSE_WAIT;
					end
				end
				TSE_WAIT: begin
					if (sub_q != 7'h00) begin
						sub_q <= sub_q - 7'h01;
					end else if (us_q == DELAY_WIDTH'(1)) begin
						st_q <= TSE_FIRE; // see [RQ12]
					end else begin
						us_q <= us_q - DELAY_WIDTH'(1);
						sub_q <= 7'(UNIT - 1);
					end
				end
				TSE_FIRE: st_q <= TSE_IDLE;
			endcase
		end
	end
	// ----------------------------------------
	// outputs
	// ----------------------------------------
	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			single_row_trigger_o <= 1'b0;
			single_image_trigger_o <= 1'b0;
			multi_image_trigger_o <= 1'b0;
			trigger_level_o <= 1'b0;
			shaft_pulse_origin_o <= 1'b0;
		end else begin
			single_row_trigger_o <= fire && trigger_target_i == `TSE_TGT_ROW; // see [RQ20]
			single_image_trigger_o <= fire && trigger_target_i == `TSE_TGT_IMAGE; // see [RQ20]
			multi_image_trigger_o <= fire && trigger_target_i == `TSE_TGT_MULTI; // see [RQ20]
			trigger_level_o <= lvl_src & lvl & trigger_arm_i; // see [RQ5] see [RQ19]
			shaft_pulse_origin_o <= shaft_pulse;
		end
	end
	// ----------------------------------------
	// assertions
	// ----------------------------------------
	sequence s_fire_row;
		fire && trigger_target_i == `TSE_TGT_ROW;
	endsequence
	property p_row_out;
		@(posedge ref_clk_i) disable iff (!rst_n) s_fire_row |=> single_row_trigger_o;
	endproperty
	a_row_out: assert property (p_row_out) else $error("row trigger missed"); // see [RQ20]
	property p_unarmed;
		@(posedge ref_clk_i) disable iff (!rst_n) (st_q == TSE_IDLE && !trigger_arm_i) |=> st_q == TSE_IDLE;
	endproperty
	a_unarmed: assert property (p_unarmed) else $error("unarmed trigger taken"); // see [RQ19]
	property p_zero_delay;
		@(posedge ref_clk_i) disable iff (!rst_n)
			(st_q == TSE_IDLE && ev && trigger_arm_i && trigger_holdoff_us_i == '0) |=> fire;
	endproperty
	a_zero_delay: assert property (p_zero_delay) else $error("zero delay not immediate"); // see [RQ12]
	property p_one_us;
		@(posedge ref_clk_i) disable iff (!rst_n)
			(st_q == TSE_IDLE && ev && trigger_arm_i && trigger_holdoff_us_i == DELAY_WIDTH'(1))
			|=> (st_q == TSE_WAIT) ##99 (st_q == TSE_WAIT) ##1 fire;
	endproperty
	a_one_us: assert property (p_one_us) else $error("one us delay wrong"); // see [RQ12]
	property p_level;
		@(posedge ref_clk_i) disable iff (!rst_n)
			(trigger_origin_select_i == `TSE_SRC_TMR_RUN && trigger_arm_i && timer_one_running_i) |=> trigger_level_o;
	endproperty
	a_level: assert property (p_level) else $error("timer level not followed"); // see [RQ5]
	property p_cnt_level;
		@(posedge ref_clk_i) disable iff (!rst_n)
			(trigger_origin_select_i == `TSE_SRC_CNT_RUN && trigger_arm_i && counter_one_running_i) |=> trigger_level_o;
	endproperty
	a_cnt_level: assert property (p_cnt_level) else $error("counter level not followed"); // see [RQ6]
	property p_shaft_row;
		@(posedge ref_clk_i) disable iff (!rst_n) (trigger_origin_select_i == `TSE_SRC_SHAFT && !is_row) |-> !ev;
	endproperty
	a_shaft_row: assert property (p_shaft_row) else $error("shaft origin outside row"); // see [RQ2]
	property p_cmd_img;
		@(posedge ref_clk_i) disable iff (!rst_n)
			(trigger_origin_select_i == `TSE_SRC_CMD1 && is_row) |-> !ev;
	endproperty
	a_cmd_img: assert property (p_cmd_img) else $error("command origin on row"); // see [RQ8]
	property p_rise;
		@(posedge ref_clk_i) disable iff (!rst_n)
			(trigger_edge_select_i == `TSE_EDGE_RISE && trigger_origin_select_i == `TSE_SRC_PIN1
			&& $rose(line_now[0]) && $stable(trigger_origin_select_i) && $stable(pin_invert_i)) |-> ev;
	endproperty
	a_rise: assert property (p_rise) else $error("rising pin edge missed"); // see [RQ10]
	property p_fall;
		@(posedge ref_clk_i) disable iff (!rst_n)
			(trigger_edge_select_i == `TSE_EDGE_FALL && trigger_origin_select_i <= `TSE_SRC_PIN3 && sel_now) |-> !ev;
	endproperty
	a_fall: assert property (p_fall) else $error("falling mode took high level"); // see [RQ11]
endmodule // tse_top

// [verif/tse_far_side.sv]
// behavioural model of the external trigger lines and the shaft encoder
`timescale 1ns/1ps
module tse_far_side (
	// clock
	input wire logic ref_clk_i,
	// lines
	output logic [2:0] pin_o,
	output logic phase_a_o,
	output logic phase_b_o
);
	logic [1:0] gray_q;
	initial begin
		pin_o = 3'h0;
		gray_q = 2'h0;
		phase_a_o = 1'b0;
		phase_b_o = 1'b0;
	end
	// one gray step, {a,b}; b_first walks 00-01-11-10
	task automatic step(input logic b_first, output logic rose);
		logic [1:0] nxt;
		nxt = b_first ? {gray_q[0], ~gray_q[1]} : {~gray_q[0], gray_q[1]};
		rose = |(nxt & ~gray_q);
		@(posedge ref_clk_i);
		#1;
		gray_q = nxt;
		phase_a_o = nxt[1];
		phase_b_o = nxt[0];
		// phases never change closer than six clocks
		repeat (5) @(posedge ref_clk_i);
	endtask
	task automatic set_pin(input integer idx, input logic val);
		@(posedge ref_clk_i);
		#1;
		pin_o[idx] = val;
		repeat (11) @(posedge ref_clk_i);
	endtask
endmodule // tse_far_side

// [verif/test_tse_top.sv]
// self-checking bench for the trigger origin selector
`timescale 1ns/1ps
module test_tse_top;
	logic ref_clk_i = 1'b0;
	logic rstn_i = 1'b0;
	logic [2:0] pin;
	logic [2:0] inv = 3'h0;
	logic [4:0] ev = 5'h00;
	logic [1:0] run = 2'h0;
	logic [1:0] tgt = 2'h1;
	logic [1:0] edg = 2'h1;
	logic [3:0] src = 4'h4;
	logic [15:0] dly = 16'h0000;
	logic arm = 1'b0;
	logic pos_mode = 1'b0;
	logic ccw = 1'b0;
	logic any_e = 1'b0;
	logic pa, pb, row_o, img_o, multi_o, lvl_o, shaft_o;
	integer miscompares = 0;
	integer checks_done = 0;
	integer cycles = 0;
	integer n_row = 0, n_img = 0, n_multi = 0, n_shaft = 0;
	integer r0, i0, m0, sh0, e_sh, rev, lat, d, k, s, t, e;
	always #5 ref_clk_i = ~ref_clk_i;
	tse_far_side tse_far_side_inst (.ref_clk_i(ref_clk_i), .pin_o(pin), .phase_a_o(pa), .phase_b_o(pb));
	tse_top #(.DELAY_WIDTH(16)) tse_top_inst (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
		.input_pin_one_i(pin[0]), .input_pin_two_i(pin[1]), .input_pin_three_i(pin[2]), .pin_invert_i(inv),
		.shaft_phase_a_i(pa), .shaft_phase_b_i(pb), .timer_one_done_event_i(ev[0]),
		.counter_one_done_event_i(ev[1]), .time_stamp_wrap_event_i(ev[2]), .broadcast_cmd_one_i(ev[3]),
		.broadcast_cmd_two_i(ev[4]), .timer_one_running_i(run[0]), .counter_one_running_i(run[1]),
		.trigger_target_i(tgt), .trigger_arm_i(arm), .trigger_origin_select_i(src),
		.trigger_edge_select_i(edg), .trigger_holdoff_us_i(dly), .shaft_output_mode_i(pos_mode),
		.shaft_forward_phase_i(ccw), .shaft_edge_select_i(any_e), .single_row_trigger_o(row_o),
		.single_image_trigger_o(img_o), .multi_image_trigger_o(multi_o), .trigger_level_o(lvl_o),
		.shaft_pulse_origin_o(shaft_o));
	always @(posedge ref_clk_i) begin
		cycles <= cycles + 1;
		n_row <= n_row + (row_o === 1'b1);
		n_img <= n_img + (img_o === 1'b1);
		n_multi <= n_multi + (multi_o === 1'b1);
		n_shaft <= n_shaft + (shaft_o === 1'b1);
	end
	// the ceiling leaves ample slack over the roughly 5.5k cycles of the run
	always @(posedge ref_clk_i) begin
		if (cycles == 60000) begin
			miscompares = miscompares + 1;
			summarize();
		end
	end
	// ----------------------------------------
	// helpers and reference model
	// ----------------------------------------
	task automatic summarize();
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done = checks_done + 1;
		if (seen !== exp) begin
			miscompares = miscompares + 1;
			$display("FAIL at %0t: seen %0d expected %0d", $time, seen, exp);
		end
	endtask
	task automatic tick(input integer n);
		repeat (n) @(posedge ref_clk_i);
		#1;
	endtask
	task automatic cfg(input logic [3:0] s_i, input logic [1:0] t_i, input logic [15:0] d_i);
		src = s_i;
		tgt = t_i;
		dly = d_i;
		arm = 1'b1;
		tick(8);
		r0 = n_row;
		i0 = n_img;
		m0 = n_multi;
		sh0 = n_shaft;
	endtask
	task automatic fire(input integer idx);
		ev[idx] = 1'b1;
		tick(1);
		ev = 5'h00;
	endtask
	function automatic integer allowed(input integer s_i, input integer t_i);
		if (s_i == 8) return 1;
		if (s_i == 4 || s_i == 5 || s_i == 9 || s_i == 10) return t_i != 0;
		return 0;
	endfunction
	task automatic shaft_run(input logic fwd, input integer n);
		logic rose;
		repeat (n) begin
			tse_far_side_inst.step(fwd ^ ccw, rose);
			if (any_e || rose) begin
				if (!pos_mode) e_sh = e_sh + 1;
				else if (!fwd) rev = (rev < 256) ? rev + 1 : 256;
				else if (rev > 0) rev = rev - 1;
				else e_sh = e_sh + 1;
			end
		end
		tick(6);
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	initial begin
		void'($urandom(14));
		tick(3);
		rstn_i = 1'b1;
		tick(5);
		check({row_o, img_o, multi_o, lvl_o, shaft_o}, 0);
		for (s = 4; s <= 10; s++) for (t = 0; t < 3; t++) if (s != 6 && s != 7) begin
			cfg(s, t, 16'h0000);
			fire(s < 6 ? s - 4 : s - 6);
			tick(12);
			e = (n_row - r0) * 256 + (n_img - i0) * 16 + (n_multi - m0);
			check(e, allowed(s, t) << (8 - 4 * t));
		end
		d = 1 + $urandom % 2;
		cfg(4'h5, 2'h1, d);
		fire(1);
		tick(20);
		fire(1);
		lat = 21;
		while (img_o !== 1'b1 && lat < 300) begin
			tick(1);
			lat = lat + 1;
		end
		check(lat >= 100 * d + 1 && lat <= 100 * d + 4, 1);
		tick(250);
		check(n_img - i0, 1);
		cfg(4'h9, 2'h1, 16'h0000);
		arm = 1'b0;
		tick(2);
		fire(3);
		tick(12);
		check(n_img - i0, 0);
		for (k = 0; k < 8; k++) begin
			cfg(6 + k % 2, 2'h1, 16'h0000);
			arm = k[1];
			run = $urandom % 4;
			tick(3);
			check(lvl_o, arm & run[k % 2]);
		end
		for (k = 0; k < 9; k++) begin
			inv = $urandom % 8;
			edg = (k == 8) ? 2'h3 : k % 3;
			cfg(k / 3, 2'h2, 16'h0000);
			e = 0;
			for (t = 0; t < 5; t++) begin
				s = $urandom % 2;
				if (s != pin[k / 3]) e = e + ((edg >= 2) || ((s ^ inv[k / 3]) == (edg == 0)));
				tse_far_side_inst.set_pin(k / 3, s);
			end
			check(n_multi - m0, e);
		end
		for (k = 0; k < 4; k++) begin
			ccw = k[0];
			any_e = k[1];
			cfg(4'h3, k[1] ? 2'h0 : 2'h1, 16'h0000);
			e_sh = 0;
			shaft_run(1'b1, 1 + $urandom % 9);
			shaft_run(1'b0, 1 + $urandom % 9);
			check(n_shaft - sh0, e_sh);
			check(n_row - r0, k[1] ? e_sh : 0);
		end
		pos_mode = 1'b1;
		ccw = $urandom % 2;
		cfg(4'h3, 2'h0, 16'h0000);
		e_sh = 0;
		rev = 0;
		shaft_run(1'b0, 5);
		shaft_run(1'b1, 8);
		shaft_run(1'b0, 300);
		shaft_run(1'b1, 300);
		check(n_shaft - sh0, e_sh);
		summarize();
	end
endmodule // test_tse_top
